//--- cfg_tap_loader.sv
// device side of the test-port configuration loader
// What this block does
// - configuration register shifts tdi in and moves data toward tdo
// - startup sequence advances on idle tck cycles under startup instruction
// - five tms-high cycles reach reset; device then fully operational
// - reconfiguration after program reset pulse or reloading the load instruction, then reload
// - tdo changes on falling tck edge
// - instruction register six bits, captures device status
// - configuration data register is sixty-four bits
// - tdo driven only in shift-dr or shift-ir
//
// how the link is sampled:
// the test clock is not a clock here, only a pin level like tms and tdi
// all three pins pass the same two flip-flops, so their relative timing survives
// a rising test clock is seen about three system clocks after the pin moves
// tms and tdi must therefore stand still for several system clocks around that edge
// a test clock well below a quarter of the system clock keeps this margin
// a glitch shorter than one system clock on the test clock pin may be lost
//
// how the shift registers move:
// the instruction shifter takes tdi at its top bit and walks toward bit 0
// after six shifts the first bit shifted sits in bit 0 of the instruction
// the configuration shifter takes tdi at bit 0 and walks toward the top bit
// the first bit of a word therefore ends at the top of the finished word
// every sixty-fourth shift under the load instruction hands over one word
// a partial word stays in the shifter until more bits or a program reset arrive
//
// how tdo behaves:
// tdo and its enable are updated only when a falling test clock is seen
// the enable is high only while the port sits in a shift state
// outside shift states the pin is released; a pull-up sets its level
//
// how startup behaves:
// startup counts idle test clocks only with the startup instruction active
// the count also needs a loaded configuration, so an empty device stays down
// the device becomes active on the twelfth counted idle clock
// leaving idle early keeps the count; the reset state clears it
//
// how program reset behaves:
// a low program reset clears loaded, active and both counters
// clearing wins over anything the port does in the same cycle
// shifting into the configuration register is ignored while it is low
// reloading the load instruction also clears loaded and active
//
module cfg_tap_loader
	import cfg_tap_pkg::*;
#(
	parameter int CFG_BITS = CFG_LEN,
	parameter int IR_BITS  = IR_LEN
)(
	// clock and reset
	input  wire logic                clk,
	input  wire logic                rstn,
	// test port pins
	input  wire tap_in_t             tapIn,
	output tap_out_t                 tapOut,
	// program reset pin, active low
	input  wire logic                program_reset_n,
	// configuration bus toward the internal configuration logic
	output logic [CFG_BITS-1:0]      cfgWord,
	output logic                     cfgWordValid,
	// status
	output logic                     cfgLoaded,
	output logic                     deviceActive
);

	// all state of this module
	typedef struct packed {
		logic [1:0]          tckSync;
		logic [1:0]          tmsSync;
		logic [1:0]          tdiSync;
		logic [1:0]          progSync;
		logic                tckLast;
		logic [IR_BITS-1:0]  irShift;
		logic [IR_BITS-1:0]  irActive;
		logic [CFG_BITS-1:0] cfgShift;
		logic [6:0]          cfgCount;
		logic [CFG_BITS-1:0] cfgWord;
		logic                cfgWordValid;
		logic                bypassBit;
		logic                cfgLoaded;
		logic [4:0]          startCount;
		logic                deviceActive;
		logic                tdoOut;
		logic                tdoOe;
	} st_t;

	st_t  s;
	st_t  next_s;
	tap_t tapState;
	logic tckRise;
	logic tckFall;

	// edges found on the second synchroniser stage only
	assign tckRise = s.tckSync[1] & ~s.tckLast;
	assign tckFall = ~s.tckSync[1] & s.tckLast;

	tap_fsm u_fsm (
		.clk     (clk),
		.rstn    (rstn),
		.tckRise (tckRise),
		.tms     (s.tmsSync[1]),
		.state   (tapState)
	);

	// next-state logic for shift registers, startup and tdo
	always_comb begin
		next_s = s;
		next_s.tckSync  = {s.tckSync[0], tapIn.tck};
		next_s.tmsSync  = {s.tmsSync[0], tapIn.tms};
		next_s.tdiSync  = {s.tdiSync[0], tapIn.tdi};
		next_s.progSync = {s.progSync[0], program_reset_n};
		next_s.tckLast  = s.tckSync[1];
		next_s.cfgWordValid = 1'b0;
		if (tckRise) begin
			case (tapState)
				TLR: begin
					next_s.irActive   = IR_RESET;
					next_s.startCount = '0;
				end
				CAP_IR: next_s.irShift = {{(IR_BITS-5){1'b0}}, s.cfgLoaded,
					s.deviceActive, 1'b0, IR_CAPTURE[1:0]};
				SH_IR: next_s.irShift = {s.tdiSync[1],
					s.irShift[IR_BITS-1:1]};
				UPD_IR: begin
					next_s.irActive = s.irShift;
					// reloading the configuration instruction clears the flags and startup count, not the word count
					if (s.irShift == OP_CFG_LOAD) begin
						next_s.cfgLoaded    = 1'b0;
						next_s.deviceActive = 1'b0;
						next_s.startCount   = '0;
					end
				end
				CAP_DR: next_s.bypassBit = 1'b0;
				SH_DR: begin
					next_s.bypassBit = s.tdiSync[1];
					if (s.irActive == OP_CFG_LOAD && s.progSync[1]) begin
						// tdi enters at the low end, data walks toward tdo
						next_s.cfgShift = {s.cfgShift[CFG_BITS-2:0],
							s.tdiSync[1]};
						if (s.cfgCount == 7'(CFG_BITS - 1)) begin
							next_s.cfgCount     = '0;
							next_s.cfgWord      = {s.cfgShift[CFG_BITS-2:0],
								s.tdiSync[1]};
							next_s.cfgWordValid = 1'b1;
							next_s.cfgLoaded    = 1'b1;
						end else begin
							next_s.cfgCount = s.cfgCount + 7'h01;
						end
					end
				end
				RTI: begin
					// startup advances only on idle clocks under startup instruction
					if (s.irActive == OP_STARTUP && s.cfgLoaded
						&& s.startCount != STARTUP_CNT_W) begin
						next_s.startCount = s.startCount + 5'h01;
						if (s.startCount == STARTUP_CNT_W - 5'h01) begin
							next_s.deviceActive = 1'b1;
						end
					end
				end
				default: ;
			endcase
		end
		// program reset pulse clears configuration, allowing reload; clear wins
		if (!s.progSync[1]) begin
			next_s.cfgLoaded    = 1'b0;
			next_s.deviceActive = 1'b0;
			next_s.cfgCount     = '0;
			next_s.startCount   = '0;
		end
		// tdo moves on the falling edge, enabled only in shift states
		if (tckFall) begin
			next_s.tdoOe = (tapState == SH_DR) || (tapState == SH_IR);
			if (tapState == SH_IR) begin
				next_s.tdoOut = s.irShift[0];
			end else if (s.irActive == OP_CFG_LOAD) begin
				next_s.tdoOut = s.cfgShift[CFG_BITS-1];
			end else begin
				next_s.tdoOut = s.bypassBit;
			end
		end
	end

	// single state register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s          <= '0;
			s.irActive <= IR_RESET;
			s.progSync <= 2'b11;
		end else begin
			s <= next_s;
		end
	end

	// outputs from flip-flops
	assign tapOut.tdoOut = s.tdoOut;
	assign tapOut.tdoOe  = s.tdoOe;
	assign cfgWord       = s.cfgWord;
	assign cfgWordValid  = s.cfgWordValid;
	assign cfgLoaded     = s.cfgLoaded;
	assign deviceActive  = s.deviceActive;

endmodule // cfg_tap_loader

//--- cfg_tap_loader_sva.sv
// port assertions for the configuration loader
module cfg_tap_loader_sva
	import cfg_tap_pkg::*;
#(
	parameter int CFG_BITS = CFG_LEN
)(
	// clock, reset, pins
	input wire logic                clk,
	input wire logic                rstn,
	input wire tap_in_t             tapIn,
	input wire tap_out_t            tapOut,
	input wire logic                program_reset_n,
	// configuration side
	input wire logic [CFG_BITS-1:0] cfgWord,
	input wire logic                cfgWordValid,
	input wire logic                cfgLoaded,
	input wire logic                deviceActive
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// program reset held past its synchroniser
	sequence progHeld;
		!program_reset_n [*4];
	endsequence
	// a word edge: the valid pulse starts or ends
	sequence validEdge;
		##[0:1] ($rose(cfgWordValid) || $fell(cfgWordValid));
	endsequence
	chk_prog_clears: assert property (progHeld |-> !cfgLoaded && !deviceActive)
		else $error("flags kept under program reset");
	chk_prog_no_word: assert property (progHeld |-> !cfgWordValid)
		else $error("word completed under program reset");
	chk_valid_pulse: assert property (cfgWordValid |=> !cfgWordValid [*8])
		else $error("word pulses too close");
	chk_word_moves: assert property ($changed(cfgWord) |-> validEdge)
		else $error("word changed without a pulse");
	chk_loaded_word: assert property ($rose(cfgLoaded) |-> validEdge)
		else $error("loaded without a word");
	chk_active_loaded: assert property ($rose(deviceActive) |-> cfgLoaded)
		else $error("active before loaded");
	chk_tdo_fall: assert property (tapOut.tdoOe && $changed(tapOut.tdoOut)
		|-> !$past(tapIn.tck, 2))
		else $error("tdo moved after a rising tck");
	chk_oe_fall: assert property ($changed(tapOut.tdoOe) |-> !$past(tapIn.tck, 2))
		else $error("tdo enable moved after a rising tck");
endmodule // cfg_tap_loader_sva

bind cfg_tap_loader cfg_tap_loader_sva #(.CFG_BITS(CFG_BITS)) cfg_tap_loader_sva_i (
	.clk(clk), .rstn(rstn), .tapIn(tapIn), .tapOut(tapOut),
	.program_reset_n(program_reset_n), .cfgWord(cfgWord), .cfgWordValid(cfgWordValid),
	.cfgLoaded(cfgLoaded), .deviceActive(deviceActive));

//--- cfg_tap_pkg.sv
// package for the test-port configuration loader: opcodes, lengths, state types
package cfg_tap_pkg;

	// register lengths
	localparam int IR_LEN      = 6;
	localparam int CFG_LEN     = 64;
	// startup sequence length in idle test clocks
	localparam int STARTUP_CNT = 12;
	localparam logic [4:0] STARTUP_CNT_W = 5'h0C;

	// instruction opcodes as held in the instruction register (bit 0 shifted first)
	localparam logic [5:0] OP_CFG_LOAD = 6'h05;   // 00101 then final 0
	localparam logic [5:0] OP_STARTUP  = 6'h0C;   // 01100 then final 0
	localparam logic [5:0] OP_BYPASS   = 6'h3F;
	// value captured into the instruction register: low two bits fixed 01
	localparam logic [5:0] IR_CAPTURE  = 6'h01;
	localparam logic [5:0] IR_RESET    = 6'h3F;

	// tap controller states
	typedef enum logic [3:0] {
		TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
		SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
	} tap_t;

	// pins of the test port as seen by the device
	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
	} tap_in_t;

	// tdo as a two-signal pin: value and enable
	typedef struct packed {
		logic tdoOut;
		logic tdoOe;
	} tap_out_t;

endpackage

//--- jtag_ctl_model.sv
// behavioural test-port controller; tck stands low between calls
module jtag_ctl_model
	import cfg_tap_pkg::*;
(
	// test port toward the device
	output tap_in_t tapIn
);
	timeunit 1ns;
	timeprecision 100ps;
	// mode pins are taken as strapped 101 at power-up; they do not reach this block
	initial tapIn = '0;
	// one 64 ns tck period; tms and tdi move only while tck is low
	task automatic tick(input logic m, input logic d);
		tapIn.tms = m;
		tapIn.tdi = d;
		#16 tapIn.tck = 1'b1;
		#32 tapIn.tck = 1'b0;
		#16;
	endtask
	// walk tms through a pattern, leftmost bit first
	task automatic walk(input logic [15:0] p, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			tick(p[i], 1'b0);
		end
	endtask
	// reset the tap, then idle and on to shift-ir
	task automatic toShiftIr();
		walk(16'h003E, 6);
		walk(16'h000C, 4);
	endtask
	// instruction, bit 0 first, last bit leaves shift-ir
	task automatic ir(input logic [5:0] op);
		for (int i = 0; i < 6; i++) begin
			tick(i == 5, op[i]);
		end
	endtask
	// data word msb first, lsb leaves shift-dr
	task automatic dr(input logic [63:0] w);
		for (int i = 63; i >= 0; i--) begin
			tick(i == 0, w[i]);
		end
	endtask
endmodule // jtag_ctl_model

//--- tap_fsm.sv
// test access port state machine, advanced on each sampled tck rising edge
module tap_fsm
	import cfg_tap_pkg::*;
(
	// clock and reset
	input  wire logic clk,
	input  wire logic rstn,
	// sampled link
	input  wire logic tckRise,
	input  wire logic tms,
	// state
	output tap_t      state
);

	tap_t next_state;

	// standard sixteen-state transition table
	always_comb begin
		next_state = state;
		if (tckRise) begin
			case (state)
				TLR:     next_state = tms ? TLR : RTI;
				RTI:     next_state = tms ? SEL_DR : RTI;
				SEL_DR:  next_state = tms ? SEL_IR : CAP_DR;
				CAP_DR:  next_state = tms ? EX1_DR : SH_DR;
				SH_DR:   next_state = tms ? EX1_DR : SH_DR;
				EX1_DR:  next_state = tms ? UPD_DR : PAU_DR;
				PAU_DR:  next_state = tms ? EX2_DR : PAU_DR;
				EX2_DR:  next_state = tms ? UPD_DR : SH_DR;
				UPD_DR:  next_state = tms ? SEL_DR : RTI;
				SEL_IR:  next_state = tms ? TLR : CAP_IR;
				CAP_IR:  next_state = tms ? EX1_IR : SH_IR;
				SH_IR:   next_state = tms ? EX1_IR : SH_IR;
				EX1_IR:  next_state = tms ? UPD_IR : PAU_IR;
				PAU_IR:  next_state = tms ? EX2_IR : PAU_IR;
				EX2_IR:  next_state = tms ? UPD_IR : SH_IR;
				UPD_IR:  next_state = tms ? SEL_DR : RTI;
				default: next_state = TLR;
			endcase
		end
	end

	// state register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state <= TLR;
		end else begin
			state <= next_state;
		end
	end

endmodule // tap_fsm

//--- testbench.sv
// bench: load, start, program reset, reload
module testbench
	import cfg_tap_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [63:0] PAT = 64'h8123_4567_89AB_CDE1;
	logic               clk = 1'b0;
	logic               rstn = 1'b0;
	logic               program_reset_n = 1'b1;
	tap_in_t            tapIn;
	tap_out_t           tapOut;
	logic [CFG_LEN-1:0] cfgWord;
	logic               cfgWordValid;
	logic               cfgLoaded;
	logic               deviceActive;
	int                 failures = 0;
	int                 compares = 0;
	int                 cycles = 0;
	int                 words = 0;
	cfg_tap_loader cfg_tap_loader_i (.clk(clk), .rstn(rstn), .tapIn(tapIn), .tapOut(tapOut),
		.program_reset_n(program_reset_n), .cfgWord(cfgWord), .cfgWordValid(cfgWordValid),
		.cfgLoaded(cfgLoaded), .deviceActive(deviceActive));
	jtag_ctl_model jtag_ctl_model_i (.tapIn(tapIn));
	always #4 clk = ~clk;
	// count word pulses and cut a hang short
	always @(posedge clk) begin
		cycles++;
		if (cfgWordValid === 1'b1) words++;
		if (cycles == 6000) begin
			failures++;
			finish_test();
		end
	end
	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic finish_test();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// load one word msb first; it must land whole
	task automatic t_load(input logic [63:0] w, input int n);
		jtag_ctl_model_i.toShiftIr();
		jtag_ctl_model_i.ir(OP_CFG_LOAD);
		jtag_ctl_model_i.walk(16'h000C, 4);
		#24 chk("oe in shift", 1, tapOut.tdoOe);
		jtag_ctl_model_i.dr(w);
		#24 chk("oe in exit", 0, tapOut.tdoOe);
		chk("word", w, cfgWord);
		chk("words", n, words);
		chk("loaded", 1, cfgLoaded);
		jtag_ctl_model_i.walk(16'h001C, 5);
	endtask
	// startup finishes on exactly the twelfth idle clock
	task automatic t_start();
		jtag_ctl_model_i.ir(OP_STARTUP);
		jtag_ctl_model_i.walk(16'h1000, 13);
		#24 chk("active at 11", 0, deviceActive);
		jtag_ctl_model_i.tick(1'b0, 1'b0);
		#24 chk("active at 12", 1, deviceActive);
		jtag_ctl_model_i.walk(16'h0007, 3);
		#24 chk("active in reset", 1, deviceActive);
	endtask
	// a device holding bypass passes tdi to tdo one shift later
	task automatic t_bypass();
		jtag_ctl_model_i.toShiftIr();
		jtag_ctl_model_i.ir(OP_BYPASS);
		jtag_ctl_model_i.walk(16'h000C, 4);
		jtag_ctl_model_i.tick(1'b0, 1'b1);
		#24 chk("bypass tdo 1", 1, tapOut.tdoOut);
		jtag_ctl_model_i.tick(1'b0, 1'b0);
		#24 chk("bypass tdo 0", 0, tapOut.tdoOut);
		jtag_ctl_model_i.tick(1'b1, 1'b0);
	endtask
	// program reset clears both flags
	task automatic t_prog();
		@(posedge clk) #1 program_reset_n = 1'b0;
		repeat (6) @(posedge clk);
		#1 chk("loaded cleared", 0, cfgLoaded);
		chk("active cleared", 0, deviceActive);
		program_reset_n = 1'b1;
	endtask
	initial begin
		repeat (16) @(posedge clk);
		#1 rstn = 1'b1;
		repeat (8) @(posedge clk);
		#1 t_load(PAT, 1);
		t_start();
		t_bypass();
		t_prog();
		t_load(~PAT, 2);
		finish_test();
	end
endmodule // testbench
